// >>> logic/irq_flag_pkg.sv
package irq_flag_pkg;

	// ----------------------------------------
	// register map, byte addresses
	// ----------------------------------------
	localparam logic [3:0] ADDR_FLAGS3 = 4'h0;
	localparam logic [3:0] ADDR_FLAGS4 = 4'h4;
	localparam logic [3:0] ADDR_ENABLE3 = 4'h8;
	localparam logic [3:0] ADDR_ENABLE4 = 4'hC;

	// ----------------------------------------
	// layout of the upper flag word
	// ----------------------------------------
	localparam int REG_WIDTH = 16;
	localparam int BIT_CAN2_TX = 7;
	localparam int BIT_CAN1_TX = 6;
	localparam int BIT_DMA7_DONE = 5;
	localparam int BIT_DMA6_DONE = 4;
	localparam int BIT_UART2_ERR = 2;
	localparam int BIT_UART1_ERR = 1;
	localparam logic [15:0] FLAGS4_IMPL_MASK = 16'h00F6;
	// lower word is only partly documented: treat all bits as plain flags
	localparam logic [15:0] FLAGS3_IMPL_MASK = 16'hFFFF;
	localparam logic [15:0] FLAGS_RESET = 16'h0000;
	localparam logic [31:0] DATA_ZERO = 32'h0000_0000;

endpackage

// >>> logic/flag_word.sv
`timescale 1ns/1ps
module flag_word #(
	parameter logic [15:0] IMPL_MASK = 16'hFFFF
)(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [15:0] setEvents,
	input wire logic writeEn,
	input wire logic [15:0] writeData,
	input wire logic [1:0] byteSel,
	output logic [15:0] flags
);

	typedef struct packed
	{
		logic [15:0] flags;
	} state_type;

	state_type stateQ;
	state_type stateD;
	logic [15:0] laneMask;

	assign laneMask = {{8{byteSel[1]}}, {8{byteSel[0]}}};
	assign flags = stateQ.flags;

	// ----------------------------------------
	// next value: write first, event set on top so it wins
	// ----------------------------------------
	always_comb
	begin
		stateD = stateQ;
		if (writeEn)
		begin
			stateD.flags = (stateQ.flags & ~laneMask) | (writeData & laneMask);
		end
		stateD.flags = (stateD.flags | setEvents) & IMPL_MASK;
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			stateQ <= '{flags: irq_flag_pkg::FLAGS_RESET};
		end
		else
		begin
			stateQ <= stateD;
		end
	end

endmodule

// >>> logic/interrupt_flag_status_bank.sv
// The register addresses and register access over Wishbone are this design's own decisions.
`timescale 1ns/1ps
module interrupt_flag_status_bank (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [15:0] flags3Events,
	input wire logic can2TxRequest,
	input wire logic can1TxRequest,
	input wire logic dmaCh7Done,
	input wire logic dmaCh6Done,
	input wire logic uart2Error,
	input wire logic uart1Error,
	output logic [15:0] pendingFlags3,
	output logic [15:0] pendingFlags4,
	output logic irq
);

	typedef struct packed
	{
		logic ack;
		logic [31:0] readData;
		logic [15:0] enable3;
		logic [15:0] enable4;
		logic [15:0] pending3;
		logic [15:0] pending4;
		logic irq;
	} state_type;

	state_type stateQ;
	state_type stateD;
	logic [15:0] events4;
	logic [15:0] flags3;
	logic [15:0] flags4;
	logic access;
	logic wrFlags3;
	logic wrFlags4;

	// ----------------------------------------
	// peripheral events into the upper word
	// ----------------------------------------
	// sources are same-clock logic, so no synchronisers
	always_comb
	begin
		events4 = 16'h0000;
		events4[irq_flag_pkg::BIT_CAN2_TX] = can2TxRequest;
		events4[irq_flag_pkg::BIT_CAN1_TX] = can1TxRequest;
		events4[irq_flag_pkg::BIT_DMA7_DONE] = dmaCh7Done;
		events4[irq_flag_pkg::BIT_DMA6_DONE] = dmaCh6Done;
		events4[irq_flag_pkg::BIT_UART2_ERR] = uart2Error;
		events4[irq_flag_pkg::BIT_UART1_ERR] = uart1Error;
	end

	// a write lands only on the single ack edge
	assign access = wb_cyc_i && wb_stb_i && !stateQ.ack;
	assign wrFlags3 = access && wb_we_i && (wb_adr_i == irq_flag_pkg::ADDR_FLAGS3);
	assign wrFlags4 = access && wb_we_i && (wb_adr_i == irq_flag_pkg::ADDR_FLAGS4);

	// ----------------------------------------
	// flag words
	// ----------------------------------------
	flag_word #(
		.IMPL_MASK(irq_flag_pkg::FLAGS3_IMPL_MASK)
	) flagWord3 (
		.clk(clk),
		.rst_n(rst_n),
		.setEvents(flags3Events),
		.writeEn(wrFlags3),
		.writeData(wb_dat_i[15:0]),
		.byteSel(wb_sel_i[1:0]),
		.flags(flags3)
	);

	flag_word #(
		.IMPL_MASK(irq_flag_pkg::FLAGS4_IMPL_MASK)
	) flagWord4 (
		.clk(clk),
		.rst_n(rst_n),
		.setEvents(events4),
		.writeEn(wrFlags4),
		.writeData(wb_dat_i[15:0]),
		.byteSel(wb_sel_i[1:0]),
		.flags(flags4)
	);

	// ----------------------------------------
	// bus slave, enables and request output
	// ----------------------------------------
	// one wait-free answer: ack one cycle after the strobe, then low a cycle
	always_comb
	begin
		stateD = stateQ;
		stateD.ack = access;
		stateD.readData = irq_flag_pkg::DATA_ZERO;
		if (access && wb_we_i && wb_adr_i == irq_flag_pkg::ADDR_ENABLE3)
		begin
			if (wb_sel_i[0])
			begin
				stateD.enable3[7:0] = wb_dat_i[7:0];
			end
			if (wb_sel_i[1])
			begin
				stateD.enable3[15:8] = wb_dat_i[15:8];
			end
		end
		if (access && wb_we_i && wb_adr_i == irq_flag_pkg::ADDR_ENABLE4)
		begin
			if (wb_sel_i[0])
			begin
				stateD.enable4[7:0] = wb_dat_i[7:0];
			end
			if (wb_sel_i[1])
			begin
				stateD.enable4[15:8] = wb_dat_i[15:8];
			end
			stateD.enable4 = stateD.enable4 & irq_flag_pkg::FLAGS4_IMPL_MASK;
		end
		if (access && !wb_we_i)
		begin
			case (wb_adr_i)
				irq_flag_pkg::ADDR_FLAGS3: stateD.readData = {16'h0000, flags3};
				irq_flag_pkg::ADDR_FLAGS4: stateD.readData = {16'h0000, flags4};
				irq_flag_pkg::ADDR_ENABLE3: stateD.readData = {16'h0000, stateQ.enable3};
				irq_flag_pkg::ADDR_ENABLE4: stateD.readData = {16'h0000, stateQ.enable4};
				default: stateD.readData = irq_flag_pkg::DATA_ZERO;
			endcase
		end
		stateD.pending3 = flags3 & stateQ.enable3;
		stateD.pending4 = flags4 & stateQ.enable4;
		stateD.irq = |{stateD.pending3, stateD.pending4};
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			stateQ <= '0;
		end
		else
		begin
			stateQ <= stateD;
		end
	end

	assign wb_ack_o = stateQ.ack;
	assign wb_dat_o = stateQ.readData;
	assign pendingFlags3 = stateQ.pending3;
	assign pendingFlags4 = stateQ.pending4;
	assign irq = stateQ.irq;

endmodule

// >>> verif/irq_source_model.sv
`timescale 1ns/1ps
// peripheral lines: fire registered one cycle late, low again a cycle after the request goes
module irq_source_model (
	input wire logic clk,
	input wire logic [31:0] fire,
	output logic [15:0] ev3,
	output logic [5:0] ev4
);
	always_ff @(posedge clk)
	begin
		ev3 <= fire[31:16];
		ev4 <= {fire[7:4], fire[2:1]};
	end
endmodule

// >>> verif/interrupt_flag_status_bank_sva.sv
`timescale 1ns/1ps
module interrupt_flag_status_bank_sva (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic can2TxRequest,
	input wire logic uart1Error,
	input wire logic [15:0] pendingFlags3,
	input wire logic [15:0] pendingFlags4,
	input wire logic irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
	a_ack: assert property (p_ack) else $error("no ack");
	property p_pulse; wb_ack_o |=> !wb_ack_o; endproperty
	a_pulse: assert property (p_pulse) else $error("long ack");
	property p_idle; !wb_ack_o |-> wb_dat_o == 32'h0000_0000; endproperty
	a_idle: assert property (p_idle) else $error("stray data");
	property p_upper; wb_dat_o[31:16] == 16'h0000; endproperty
	a_upper: assert property (p_upper) else $error("upper data");
	property p_rsv; (pendingFlags4 & 16'hFF09) == 16'h0000; endproperty
	a_rsv: assert property (p_rsv) else $error("reserved set");
	property p_irq; irq == (|pendingFlags3 || |pendingFlags4); endproperty
	a_irq: assert property (p_irq) else $error("irq level");
	property p_rise7; $rose(pendingFlags4[7]) |-> $past(can2TxRequest || wb_we_i, 2); endproperty
	a_rise7: assert property (p_rise7) else $error("bit 7 cause");
	property p_rise1; $rose(pendingFlags4[1]) |-> $past(uart1Error || wb_we_i, 2); endproperty
	a_rise1: assert property (p_rise1) else $error("bit 1 cause");
endmodule
bind interrupt_flag_status_bank interrupt_flag_status_bank_sva u_sva (.clk, .rst_n, .wb_cyc_i,
	.wb_stb_i, .wb_we_i, .wb_dat_o, .wb_ack_o, .can2TxRequest, .uart1Error, .pendingFlags3,
	.pendingFlags4, .irq);

// >>> verif/interrupt_flag_status_bank_tb_top.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin failures++; \
	$display("MISMATCH %s exp %h got %h", n, e, g); end end
module interrupt_flag_status_bank_tb_top;
	logic clk, rst_n, cyc, stb, we, ack, irq;
	logic [3:0] adr, sel;
	logic [31:0] wdat, rdat, got, fire;
	logic [15:0] ev3, p3, p4;
	logic [5:0] ev4;
	int failures, cmp_count, cycles;
	irq_source_model u_irq_source_model (.clk, .fire, .ev3, .ev4);
	interrupt_flag_status_bank u_interrupt_flag_status_bank (.clk, .rst_n, .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .flags3Events(ev3), .can2TxRequest(ev4[5]),
		.can1TxRequest(ev4[4]), .dmaCh7Done(ev4[3]), .dmaCh6Done(ev4[2]), .uart2Error(ev4[1]),
		.uart1Error(ev4[0]), .pendingFlags3(p3), .pendingFlags4(p4), .irq);
	// clock, plus a cycle ceiling so a hung handshake still ends the run
	initial
	begin
		clk = 0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			failures++;
			tally_and_finish();
		end
	end
	// one classic cycle: hold until ack is sampled, then idle a cycle
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= a;
		wdat <= d;
		@(posedge clk);
		while (ack !== 1'b1)
			@(posedge clk);
		got = rdat;
		cyc <= 0;
		stb <= 0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		bus(0, a, 0);
		`CHK("read", e, got)
	endtask
	task automatic pulse(input logic [31:0] f);
		fire <= f;
		repeat (4) @(posedge clk);
		fire <= 0;
	endtask
	task automatic t_events;
		for (int i = 0; i < 16; i++)
			if (irq_flag_pkg::FLAGS4_IMPL_MASK[i])
			begin
				pulse(32'h1 << i);
				rd(4'h4, 32'h1 << i);
				bus(1, 4'h4, 0);
				rd(4'h4, 0);
			end
		pulse(32'h8001_0000);
		rd(4'h0, 32'h0000_8001);
	endtask
	// enables gate irq; bits set by software, reserved ones dropped
	task automatic t_gate;
		bus(1, 4'h4, 32'h0000_FFFF);
		rd(4'h4, 32'h0000_00F6);
		// a write to the high lane only must leave the low flag byte alone
		sel <= 4'h2;
		bus(1, 4'h4, 0);
		sel <= 4'hF;
		rd(4'h4, 32'h0000_00F6);
		rd(4'h1, 0);
		bus(1, 4'hC, 32'h0000_0002);
		rd(4'hC, 32'h0000_0002);
		`CHK("pend", 16'h0002, p4)
		`CHK("irq on", 1'b1, irq)
		bus(1, 4'h8, 32'h0000_0001);
		`CHK("pend3", 16'h0001, p3)
		bus(1, 4'h0, 0);
		bus(1, 4'h4, 32'h0000_00F4);
		`CHK("irq", 1'b0, irq)
	endtask
	// event and software clear land on the same edge: the event wins
	task automatic t_race;
		fire <= 32'h80;
		@(posedge clk);
		fire <= 0;
		bus(1, 4'h4, 0);
		rd(4'h4, 32'h0000_0080);
	endtask
	task automatic tally_and_finish;
		$display("compares %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial
	begin
		{rst_n, cyc, stb, we, adr, wdat, fire} = 0;
		sel = 4'hF;
		repeat (5) @(posedge clk);
		rst_n <= 1;
		rd(4'h4, 0);
		rd(4'h0, 0);
		t_events();
		t_gate();
		t_race();
		tally_and_finish();
	end
endmodule
